// ---- dv/pad_model.sv ----
`timescale 1ns/1ps
module pad_model (
    input wire logic clock, // system clock
    input wire logic [31:0] pad_out_reg, // device drive values
    input wire logic [31:0] pad_oe_reg, // device drive enables
    input wire logic [31:0] pull_up_reg, // device pull-up enables
    input wire logic [31:0] ext_en, // far side drives the line
    input wire logic [31:0] ext_val, // far side drive value
    output logic [31:0] pad_in // resolved pad level
);
    logic [31:0] float_reg = 32'h00000000;
    // an unpulled floating line wanders, so a lost pull-up shows
    always_ff @(posedge clock)
    begin
        float_reg <= ~float_reg;
    end
    always_comb
    begin
        pad_in = (pad_oe_reg & pad_out_reg) | (~pad_oe_reg & ext_en & ext_val)
            | (~pad_oe_reg & ~ext_en & (pull_up_reg | float_reg));
    end
endmodule : pad_model

// ---- dv/tb_periph_map_mux.sv ----
`timescale 1ns/1ps
module tb_periph_map_mux;
    import periph_map_pkg::*;
    logic clock, arst_n, addr_valid, cfg_write;
    logic [31:0] addr_in, src, clk_gate_by_id, cfg_periph, cfg_func_b, cfg_pull_up;
    logic [31:0] gpio_out, gpio_oe, func_a_out, func_a_oe, func_b_out, func_b_oe;
    logic [31:0] ext_en, ext_val, pad_in, irq_by_id_reg, clk_en_by_id_reg;
    logic [31:0] pad_out_reg, pad_oe_reg, pull_up_reg, line_peripheral_status;
    logic [31:0] func_a_in_reg, func_b_in_reg, gpio_in_reg, status2, pad_oe2;
    logic window_hit_reg, bus32_allowed_reg, bus32_2;
    logic [SLOT_W-1:0] slot_index_reg;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    periph_map_mux periph_map_mux_i (.*, .fast_irq_in(src[0]), .sys_irq_in(src[1]),
        .pio_irq(src[5:2]), .usart_irq(src[9:6]), .card_irq(src[10]), .usb_dev_irq(src[11]),
        .two_wire_irq(src[12]), .spi_irq(src[13]), .ssc_irq(src[16:14]),
        .timer_irq(src[22:17]), .usb_host_irq(src[23]), .mac_irq(src[24]),
        .ext_int_0_pin(src[25]));
    // second copy: memory lines reset to function a, upper half shared with the bus
    periph_map_mux #(.RESET_PERIPH(32'h00003F80), .WIDE_BUS_LINES(32'hFFFF0000))
        periph_map_mux_wide_i (.*, .fast_irq_in(src[0]), .sys_irq_in(src[1]),
        .pio_irq(src[5:2]), .usart_irq(src[9:6]), .card_irq(src[10]), .usb_dev_irq(src[11]),
        .two_wire_irq(src[12]), .spi_irq(src[13]), .ssc_irq(src[16:14]),
        .timer_irq(src[22:17]), .usb_host_irq(src[23]), .mac_irq(src[24]),
        .ext_int_0_pin(src[25]), .window_hit_reg(), .slot_index_reg(), .irq_by_id_reg(),
        .clk_en_by_id_reg(), .pad_out_reg(), .pad_oe_reg(pad_oe2), .pull_up_reg(),
        .line_peripheral_status(status2), .func_a_in_reg(), .func_b_in_reg(),
        .gpio_in_reg(), .bus32_allowed_reg(bus32_2));
    pad_model pad_model_i (.clock(clock), .pad_out_reg(pad_out_reg), .pad_oe_reg(pad_oe_reg),
        .pull_up_reg(pull_up_reg), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask : step
    // settles pad sync and the extra stage of the external interrupt map
    task automatic cfg(input logic [31:0] p, input logic [31:0] b, input logic [31:0] u);
        cfg_periph = p;
        cfg_func_b = b;
        cfg_pull_up = u;
        cfg_write = 1'b1;
        step(1);
        cfg_write = 1'b0;
        step(6);
    endtask : cfg
    task automatic t_reset;
        step(2);
        check(line_peripheral_status, 32'h00000000);
        check(pull_up_reg, 32'hFFFFFFFF);
        check(pad_oe_reg, 32'h00000000);
        check(status2, 32'h00003F80);
        arst_n = 1'b1;
        step(1);
        check(pad_oe2 & 32'h00003F80, 32'h00003F80);
        check({31'h0, bus32_2}, 32'h00000000);
    endtask : t_reset
    task automatic t_decode;
        logic [31:0] tab [7] = '{32'hFFFA0000, 32'hFFF9FFFF, 32'hFFFA4000, 32'hFFFE3FFF,
            32'hFFFE4000, 32'hFFFA7FFF, 32'hFFFA4000};
        logic hv;
        logic [31:0] es;
        for (int i = 0; i < 7; i++)
        begin
            addr_in = tab[i];
            addr_valid = (i != 6);
            hv = addr_valid && tab[i] >= 32'hFFFA0000 && tab[i] <= 32'hFFFE3FFF;
            es = hv ? (tab[i] - 32'hFFFA0000) >> 14 : 32'h00000000;
            step(1);
            check({26'h0, window_hit_reg, slot_index_reg}, {26'h0, hv, es[4:0]});
        end
        addr_valid = 1'b0;
    endtask : t_decode
    task automatic t_ids;
        for (int id = 0; id < 26; id++)
        begin
            src = 32'h00000001 << id;
            clk_gate_by_id = ~src;
            step(1);
            check(irq_by_id_reg, src);
            check(clk_en_by_id_reg, ~src);
        end
        src = 32'h00000000;
    endtask : t_ids
    task automatic t_ext;
        int ln [6] = '{26, 25, 23, 2, 3, 16};
        cfg(32'h0681000C, 32'h0681000C, 32'hFFFFFFFF);
        check(irq_by_id_reg, 32'hFC000000);
        for (int k = 0; k < 6; k++)
        begin
            ext_en = 32'h00000001 << ln[k];
            step(6);
            check(irq_by_id_reg, 32'hFC000000 & ~(32'h04000000 << k));
        end
        ext_en = 32'h00000000;
    endtask : t_ext
    task automatic t_mux;
        logic [31:0] p, b, eo, ep, pad;
        p = 32'hFF00FF01;
        func_a_out = 32'hAAAA5555;
        func_a_oe = 32'hFFFF0000;
        func_b_out = 32'h12345678;
        func_b_oe = 32'h0000FFFF;
        gpio_out = 32'h3C3C3C3C;
        gpio_oe = 32'h0F0F0F0F;
        for (int j = 0; j < 2; j++)
        begin
            b = j ? 32'h0F0F0F0F : 32'hF0F0F0F0;
            cfg(p, b, 32'hFFFFFFFF);
            ep = (p & b & func_b_out) | (p & ~b & func_a_out) | (~p & gpio_out);
            eo = (p & b & func_b_oe) | (p & ~b & func_a_oe) | (~p & gpio_oe);
            pad = (eo & ep) | ~eo;
            check(line_peripheral_status, p);
            check(pad_out_reg, ep);
            check(pad_oe_reg, eo);
            check(func_a_in_reg, p & ~b & pad);
            check(func_b_in_reg, p & b & pad);
            check(gpio_in_reg & ~p, pad & ~p);
        end
    endtask : t_mux
    task automatic t_bus32;
        gpio_oe = 32'h00000000;
        cfg(32'hFFFF0000, 32'h00000000, 32'h0000FFFF);
        check({31'h0, bus32_2}, 32'h00000001);
        check({31'h0, bus32_allowed_reg}, 32'h00000001);
        check(pull_up_reg, 32'h0000FFFF);
        check(gpio_in_reg & 32'h0000FFFF, 32'h0000FFFF);
        cfg(32'hFFFE0000, 32'h00000000, 32'hFFFFFFFF);
        check({31'h0, bus32_2}, 32'h00000000);
    endtask : t_bus32
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial
    begin
        {arst_n, addr_valid, cfg_write} = 3'b000;
        {addr_in, src, clk_gate_by_id, cfg_periph, cfg_func_b, cfg_pull_up} = '0;
        {gpio_out, gpio_oe, func_a_out, func_b_out, func_b_oe, ext_en, ext_val} = '0;
        func_a_oe = 32'hFFFFFFFF;
        t_reset();
        t_decode();
        t_ids();
        t_ext();
        t_mux();
        t_bus32();
        complete_run();
    end
endmodule : tb_periph_map_mux

// ---- verilog/line_route.sv ----
`timescale 1ns/1ps
module line_route
    import periph_map_pkg::*;
(
    input wire logic periph_mode, // line handed to a peripheral
    input wire logic use_b, // function b selected
    input wire logic gpio_out, // general i/o drive value
    input wire logic gpio_oe, // general i/o drive enable
    input wire logic a_out, // function a drive value
    input wire logic a_oe, // function a drive enable
    input wire logic b_out, // function b drive value
    input wire logic b_oe, // function b drive enable
    input wire logic pad_level, // synchronised pad level
    output logic pad_out, // value toward the pad
    output logic pad_oe, // drive enable toward the pad
    output logic a_in, // pad level seen by function a
    output logic b_in // pad level seen by function b
);
    always_comb
    begin
        pad_out = gpio_out;
        pad_oe = gpio_oe;
        a_in = INACTIVE_IN;
        b_in = INACTIVE_IN;
        if (periph_mode)
        begin
            pad_out = use_b ? b_out : a_out;
            pad_oe = use_b ? b_oe : a_oe;
            if (use_b)
                b_in = pad_level;
            else
                a_in = pad_level;
        end
    end
endmodule : line_route

// ---- verilog/periph_map_mux.sv ----
`timescale 1ns/1ps
module periph_map_mux #(
    parameter logic [31:0] RESET_PERIPH = 32'h00000000, // lines reset to a function
    parameter logic [31:0] RESET_FUNC_B = 32'h00000000, // of those, function b
    parameter logic [31:0] WIDE_BUS_LINES = 32'h00000000 // lines shared with bus bits 16-31
) (
    input wire logic clock, // 100 MHz system clock
    input wire logic arst_n, // external reset, async active low
    input wire logic [31:0] addr_in, // bus address to decode
    input wire logic addr_valid, // address qualifier
    output logic window_hit_reg, // address lies in the peripheral window
    output logic [periph_map_pkg::SLOT_W-1:0] slot_index_reg, // slot number in window
    input wire logic fast_irq_in, // fast interrupt source
    input wire logic sys_irq_in, // system_irq_source combined request
    input wire logic [periph_map_pkg::NUM_PIO-1:0] pio_irq, // i/o controller requests
    input wire logic [periph_map_pkg::NUM_USART-1:0] usart_irq, // usart requests
    input wire logic card_irq, // card interface request
    input wire logic usb_dev_irq, // usb device request
    input wire logic two_wire_irq, // two-wire request
    input wire logic spi_irq, // spi request
    input wire logic [periph_map_pkg::NUM_SSC-1:0] ssc_irq, // ssc requests
    input wire logic [periph_map_pkg::NUM_TIMER-1:0] timer_irq, // timer requests
    input wire logic usb_host_irq, // usb host request
    input wire logic mac_irq, // mac request
    input wire logic ext_int_0_pin, // ext interrupt 0 from another controller
    input wire logic [periph_map_pkg::NUM_IDS-1:0] clk_gate_by_id, // power manager gates
    output logic [periph_map_pkg::NUM_IDS-1:0] irq_by_id_reg, // interrupt inputs by id
    output logic [periph_map_pkg::NUM_IDS-1:0] clk_en_by_id_reg, // clock enables by id
    input wire logic cfg_write, // load line configuration
    input wire logic [31:0] cfg_periph, // 1 hands the line to a peripheral
    input wire logic [31:0] cfg_func_b, // 1 selects function b
    input wire logic [31:0] cfg_pull_up, // 1 enables the pull-up
    input wire logic [31:0] gpio_out, // general i/o drive values
    input wire logic [31:0] gpio_oe, // general i/o drive enables
    input wire logic [31:0] func_a_out, // function a drive values
    input wire logic [31:0] func_a_oe, // function a drive enables
    input wire logic [31:0] func_b_out, // function b drive values
    input wire logic [31:0] func_b_oe, // function b drive enables
    input wire logic [31:0] pad_in, // pad levels, asynchronous
    output logic [31:0] pad_out_reg, // pad drive values
    output logic [31:0] pad_oe_reg, // pad drive enables, high drives
    output logic [31:0] pull_up_reg, // pad pull-up enables
    output logic [31:0] line_peripheral_status, // 1 where line is in peripheral mode
    output logic [31:0] func_a_in_reg, // pad levels for function a
    output logic [31:0] func_b_in_reg, // pad levels for function b
    output logic [31:0] gpio_in_reg, // pad levels for general i/o
    output logic bus32_allowed_reg // no shared bus line is held as general i/o
);
    import periph_map_pkg::*;

    if ((RESET_FUNC_B & ~RESET_PERIPH) != 32'h00000000)
    begin : g_bad_reset_b
        $error("function b reset set on a line that resets to i/o");
    end

    // address decode
    logic window_hit_next;
    logic [SLOT_W-1:0] slot_index_next;
    logic [31:0] offset;

    always_comb
    begin
        offset = addr_in - WIN_BASE;
        window_hit_next = addr_valid && (addr_in >= WIN_BASE) && (addr_in <= WIN_LAST);
        slot_index_next = window_hit_next ? offset[SLOT_SHIFT +: SLOT_W] : '0;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            window_hit_reg <= 1'b0;
            slot_index_reg <= '0;
        end
        else
        begin
            window_hit_reg <= window_hit_next;
            slot_index_reg <= slot_index_next;
        end
    end

    // pad synchroniser; first stage read only by the second
    logic [31:0] pad_meta_reg;
    logic [31:0] pad_sync_reg;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pad_meta_reg <= 32'hFFFFFFFF;
            pad_sync_reg <= 32'hFFFFFFFF;
        end
        else
        begin
            pad_meta_reg <= pad_in;
            pad_sync_reg <= pad_meta_reg;
        end
    end

    // line configuration; reset values come from constants so memory lines drive at once
    logic [31:0] sel_b_reg;
    logic [31:0] periph_next;
    logic [31:0] sel_b_next;
    logic [31:0] pull_up_next;

    always_comb
    begin
        periph_next = line_peripheral_status;
        sel_b_next = sel_b_reg;
        pull_up_next = pull_up_reg;
        if (cfg_write)
        begin
            periph_next = cfg_periph;
            sel_b_next = cfg_func_b;
            pull_up_next = cfg_pull_up;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            line_peripheral_status <= RST_PERIPH_STATUS | RESET_PERIPH;
            sel_b_reg <= RST_SEL_B | RESET_FUNC_B;
            pull_up_reg <= RST_PULL_UP;
        end
        else
        begin
            line_peripheral_status <= periph_next;
            sel_b_reg <= sel_b_next;
            pull_up_reg <= pull_up_next;
        end
    end

    // per-line routing; the fixed signal assignment per line lives in the wiring outside
    logic [31:0] pad_out_next;
    logic [31:0] pad_oe_next;
    logic [31:0] a_in_next;
    logic [31:0] b_in_next;

    genvar gl;
    generate
        for (gl = 0; gl < NUM_LINES; gl++)
        begin : g_line
            line_route u_route (
                .periph_mode(line_peripheral_status[gl]),
                .use_b(sel_b_reg[gl]),
                .gpio_out(gpio_out[gl]),
                .gpio_oe(gpio_oe[gl]),
                .a_out(func_a_out[gl]),
                .a_oe(func_a_oe[gl]),
                .b_out(func_b_out[gl]),
                .b_oe(func_b_oe[gl]),
                .pad_level(pad_sync_reg[gl]),
                .pad_out(pad_out_next[gl]),
                .pad_oe(pad_oe_next[gl]),
                .a_in(a_in_next[gl]),
                .b_in(b_in_next[gl])
            );
        end
    endgenerate

    logic bus32_next;

    always_comb
    begin
        bus32_next = &(line_peripheral_status | ~WIDE_BUS_LINES);
    end

    // pad outputs registered: one cycle from selection change to pin
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pad_out_reg <= 32'h00000000;
            pad_oe_reg <= 32'h00000000;
            func_a_in_reg <= 32'h00000000;
            func_b_in_reg <= 32'h00000000;
            gpio_in_reg <= 32'h00000000;
            // mirrors the reset line modes so the flag is right from the first edge
            bus32_allowed_reg <= &(RST_PERIPH_STATUS | RESET_PERIPH | ~WIDE_BUS_LINES);
        end
        else
        begin
            pad_out_reg <= pad_out_next;
            pad_oe_reg <= pad_oe_next;
            func_a_in_reg <= a_in_next;
            func_b_in_reg <= b_in_next;
            gpio_in_reg <= pad_sync_reg;
            bus32_allowed_reg <= bus32_next;
        end
    end

    // identifier numbering
    logic [NUM_EXT-1:0] ext_int;
    logic [NUM_IDS-1:0] irq_next;
    logic [NUM_IDS-1:0] clk_next;

    always_comb
    begin
        ext_int = {func_b_in_reg[LINE_EXT_INT_6], func_b_in_reg[LINE_EXT_INT_5],
                   func_b_in_reg[LINE_EXT_INT_4], func_b_in_reg[LINE_EXT_INT_3],
                   func_b_in_reg[LINE_EXT_INT_2], func_b_in_reg[LINE_EXT_INT_1],
                   ext_int_0_pin};
        irq_next = '0;
        irq_next[ID_FAST_IRQ] = fast_irq_in;
        irq_next[ID_SYS_IRQ] = sys_irq_in;
        irq_next[ID_PIO_BASE +: NUM_PIO] = pio_irq;
        irq_next[ID_USART_BASE +: NUM_USART] = usart_irq;
        irq_next[ID_CARD] = card_irq;
        irq_next[ID_USB_DEV] = usb_dev_irq;
        irq_next[ID_TWO_WIRE] = two_wire_irq;
        irq_next[ID_SPI] = spi_irq;
        irq_next[ID_SSC_BASE +: NUM_SSC] = ssc_irq;
        irq_next[ID_TIMER_BASE +: NUM_TIMER] = timer_irq;
        irq_next[ID_USB_HOST] = usb_host_irq;
        irq_next[ID_MAC] = mac_irq;
        irq_next[ID_EXT_BASE +: NUM_EXT] = ext_int;
        clk_next = clk_gate_by_id;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_by_id_reg <= '0;
            clk_en_by_id_reg <= '0;
        end
        else
        begin
            irq_by_id_reg <= irq_next;
            clk_en_by_id_reg <= clk_next;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence cfg_load_s;
        cfg_write;
    endsequence

    // the first edge after release would compare against inputs seen in reset
    sequence settled_s;
        $past(arst_n);
    endsequence

    window_bounds_a: assert property (window_hit_reg |->
        $past(addr_in) >= 32'hFFFA0000 && $past(addr_in) <= 32'hFFFE3FFF && $past(addr_valid))
        else $error("window hit outside the peripheral window");
    slot_calc_a: assert property (window_hit_reg |->
        slot_index_reg == 5'(($past(addr_in) - 32'hFFFA0000) >> 14))
        else $error("slot index wrong");
    fast_id_a: assert property (settled_s |->
        irq_by_id_reg[0] == $past(fast_irq_in) && irq_by_id_reg[1] == $past(sys_irq_in))
        else $error("fast or system id misplaced");
    clk_map_a: assert property (settled_s |-> clk_en_by_id_reg == $past(clk_gate_by_id))
        else $error("clock enable misplaced");
    pio_usart_id_a: assert property (settled_s |->
        irq_by_id_reg[5:2] == $past(pio_irq) && irq_by_id_reg[9:6] == $past(usart_irq))
        else $error("controller or usart id misplaced");
    mac_host_id_a: assert property (settled_s |->
        irq_by_id_reg[24] == $past(mac_irq) && irq_by_id_reg[23] == $past(usb_host_irq)
        && irq_by_id_reg[13] == $past(spi_irq))
        else $error("peripheral id misplaced");
    group_id_a: assert property (settled_s |->
        irq_by_id_reg[22:17] == $past(timer_irq) && irq_by_id_reg[16:14] == $past(ssc_irq)
        && irq_by_id_reg[12:10] == {$past(two_wire_irq), $past(usb_dev_irq), $past(card_irq)})
        else $error("timer, ssc or small peripheral id misplaced");
    ext_int_id_a: assert property (settled_s |->
        irq_by_id_reg[25] == $past(ext_int_0_pin)
        && irq_by_id_reg[29] == $past(func_b_in_reg[2])
        && irq_by_id_reg[31] == $past(func_b_in_reg[16]))
        else $error("external interrupt id misplaced");
    wide_bus_a: assert property (bus32_allowed_reg ==
        $past(&(line_peripheral_status | ~WIDE_BUS_LINES)))
        else $error("32-bit bus permission wrong");
    cfg_take_a: assert property (cfg_load_s |=>
        line_peripheral_status == $past(cfg_periph) && sel_b_reg == $past(cfg_func_b))
        else $error("line configuration not loaded");
    pull_take_a: assert property (cfg_load_s |=> pull_up_reg == $past(cfg_pull_up))
        else $error("pull-up enables not loaded");
    cfg_hold_a: assert property (!cfg_write |=> $stable(line_peripheral_status))
        else $error("line mode changed without a load");
    route_sel_a: assert property ((line_peripheral_status[0] && sel_b_reg[0]) |=>
        pad_oe_reg[0] == $past(func_b_oe[0]) && func_a_in_reg[0] == 1'b0)
        else $error("function b routing wrong on line 0");
    route_fa_a: assert property ((line_peripheral_status[8] && !sel_b_reg[8]) |=>
        pad_out_reg[8] == $past(func_a_out[8]) && func_b_in_reg[8] == 1'b0)
        else $error("function a routing wrong on line 8");
    gpio_route_a: assert property (!line_peripheral_status[5] |=>
        pad_oe_reg[5] == $past(gpio_oe[5]) && func_b_in_reg[5] == 1'b0)
        else $error("general i/o routing wrong on line 5");
endmodule : periph_map_mux

// ---- verilog/periph_map_pkg.sv ----
package periph_map_pkg;
    // user peripheral window and slot size
    localparam logic [31:0] WIN_BASE = 32'hFFFA0000;
    localparam logic [31:0] WIN_LAST = 32'hFFFE3FFF;
    localparam int SLOT_BYTES = 16384;
    localparam int SLOT_SHIFT = $clog2(SLOT_BYTES);
    localparam int SLOT_W = 5;
    localparam int NUM_LINES = 32;
    localparam int NUM_IDS = 32;
    // peripheral identifiers
    localparam int ID_FAST_IRQ = 0;
    localparam int ID_SYS_IRQ = 1;
    localparam int ID_PIO_BASE = 2;
    localparam int ID_USART_BASE = 6;
    localparam int ID_CARD = 10;
    localparam int ID_USB_DEV = 11;
    localparam int ID_TWO_WIRE = 12;
    localparam int ID_SPI = 13;
    localparam int ID_SSC_BASE = 14;
    localparam int ID_TIMER_BASE = 17;
    localparam int ID_USB_HOST = 23;
    localparam int ID_MAC = 24;
    localparam int ID_EXT_BASE = 25;
    localparam int NUM_PIO = 4;
    localparam int NUM_USART = 4;
    localparam int NUM_SSC = 3;
    localparam int NUM_TIMER = 6;
    localparam int NUM_EXT = 7;
    // lines of the first controller carrying external interrupts as function b
    localparam int LINE_EXT_INT_1 = 26;
    localparam int LINE_EXT_INT_2 = 25;
    localparam int LINE_EXT_INT_3 = 23;
    localparam int LINE_EXT_INT_4 = 2;
    localparam int LINE_EXT_INT_5 = 3;
    localparam int LINE_EXT_INT_6 = 16;
    // function a groups on the first controller
    localparam int LINE_SPI_FIRST = 0;
    localparam int LINE_MAC_FIRST = 7;
    localparam int LINE_USART_FIRST = 17;
    localparam int LINE_MISC_FIRST = 25;
    // reset values
    localparam logic [31:0] RST_PERIPH_STATUS = 32'h00000000;
    localparam logic [31:0] RST_PULL_UP = 32'hFFFFFFFF;
    localparam logic [31:0] RST_SEL_B = 32'h00000000;
    localparam logic INACTIVE_IN = 1'b0;
endpackage : periph_map_pkg
